// ==== design/peripheral_interrupt_enable.sv ====
// peripheral interrupt enable register with flag capture and apb access
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_enable
	import periph_irq_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	input  wire logic [7:0]  event_in,
	output logic             pready_out,
	output logic [31:0]      prdata_out,
	output logic             pslverr_out,
	output logic [7:0]       enable_out,
	output logic             irq_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam logic [7:0] IMPL_MASK = LARGE_VARIANT ? LARGE_MASK : SMALL_MASK;
	// flags exist only where an enable exists
	localparam logic [7:0] FLAG_MASK = IMPL_MASK;

	irq_state_t state_reg;
	irq_state_t state_next;

	logic       setup;
	logic       access;
	logic       wr_en;
	logic [7:0] set_bits;
	logic [7:0] wbyte;

	assign setup  = psel_in && !penable_in;
	// a write lands only at the edge that completes the transfer
	assign access = psel_in && penable_in && state_reg.ready;
	assign wbyte  = pwdata_in[7:0];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.ready = 1'b0;
		state_next.slverr = 1'b0;
		state_next.rdata = READ_ZERO;
		wr_en = pstrb_in[0];
		set_bits = event_in & FLAG_MASK;

		// no wait state: answer in the first access cycle after setup
		if (setup) begin
			state_next.ready = 1'b1;
			case (paddr_in)
				ENABLE_ADDR: begin
					state_next.rdata[7:0] = state_reg.enable;
				end
				FLAG_ADDR: begin
					state_next.rdata[7:0] = state_reg.flags;
				end
				CONTROL_ADDR: begin
					state_next.rdata[MASTER_EN_BIT] = state_reg.master_en;
				end
				default: begin
					state_next.slverr = 1'b1;
				end
			endcase
		end
		if (access && pwrite_in && wr_en) begin
			case (paddr_in)
				ENABLE_ADDR: begin
					state_next.enable = wbyte & IMPL_MASK;
				end
				FLAG_ADDR: begin
					// write one to clear; new events beat the clear
					state_next.flags = state_reg.flags & ~wbyte;
				end
				CONTROL_ADDR: begin
					state_next.master_en = wbyte[MASTER_EN_BIT];
				end
				default: begin
					state_next.slverr = 1'b0;
				end
			endcase
		end
		state_next.flags = state_next.flags | set_bits;

		// master enable gates the combined request
		state_next.irq = state_next.master_en && |(state_next.flags & state_next.enable);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= '{enable: ENABLE_RESET, flags: FLAG_RESET, master_en: 1'b0,
				irq: 1'b0, ready: 1'b0, rdata: READ_ZERO, slverr: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign pready_out  = state_reg.ready;
	assign prdata_out  = state_reg.rdata;
	assign pslverr_out = state_reg.slverr;
	assign enable_out  = state_reg.enable;
	assign irq_out     = state_reg.irq;

endmodule
`default_nettype wire

// ==== include/periph_irq_pkg.sv ====
// package: register map, field positions and carriers of the peripheral interrupt enable block
package periph_irq_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ENABLE_ADDR  = 12'h08c;
	localparam logic [11:0] FLAG_ADDR    = 12'h090;
	localparam logic [11:0] CONTROL_ADDR = 12'h094;
	localparam logic [7:0]  ENABLE_RESET = 8'h00;
	localparam logic [7:0]  FLAG_RESET   = 8'h00;
	localparam logic [31:0] READ_ZERO    = 32'h00000000;

	// ----------------------------------------------------------------
	// field positions of the enable, flag and control registers
	// ----------------------------------------------------------------
	localparam int TIMER1_OVF_BIT   = 0;
	localparam int TIMER2_MATCH_BIT = 1;
	localparam int CAPCOMP1_BIT     = 2;
	localparam int SERIAL_PORT_BIT  = 3;
	localparam int SERIAL_TX_BIT    = 4;
	localparam int SERIAL_RX_BIT    = 5;
	localparam int RESERVED_BIT     = 6;
	localparam int HOST_PORT_BIT    = 7;
	localparam int MASTER_EN_BIT    = 0;

	// implemented bits: small variant lacks the serial rx/tx enables
	localparam logic [7:0] LARGE_MASK = 8'hbf;
	localparam logic [7:0] SMALL_MASK = 8'h8f;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  enable;
		logic [7:0]  flags;
		logic        master_en;
		logic        irq;
		logic        ready;
		logic [31:0] rdata;
		logic        slverr;
	} irq_state_t;

endpackage

// ==== test/periph_irq_assertions.sv ====
// checker of the enable register block
`timescale 1ns/1ps
`default_nettype none
module periph_irq_checker import periph_irq_pkg::*; (
	input wire logic        clk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, irq_out,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in, prdata_out,
	input wire logic [7:0]  enable_out,
	input wire logic [3:0]  pstrb_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire s = psel_in && !penable_in;
	wire w = s && pwrite_in && pstrb_in[0] && paddr_in == ENABLE_ADDR;
	property p_w; w |-> ##2 enable_out == ($past(pwdata_in[7:0], 2) & LARGE_MASK); endproperty
	a_w: assert property (p_w) else $error("enable write");
	property p_res; enable_out[RESERVED_BIT] == 1'b0; endproperty
	a_res: assert property (p_res) else $error("reserved bit");
	property p_rd; pready_out && !pwrite_in && paddr_in == ENABLE_ADDR |-> prdata_out == {24'h0, enable_out}; endproperty
	a_rd: assert property (p_rd) else $error("enable read");
	property p_rdy; s |=> pready_out ##1 !pready_out; endproperty
	a_rdy: assert property (p_rdy) else $error("ready pulse");
	property p_irq; irq_out |-> enable_out != 8'h00; endproperty
	a_irq: assert property (p_irq) else $error("unmasked irq");
	property p_hi; pready_out && paddr_in > CONTROL_ADDR |-> pslverr_out && prdata_out == READ_ZERO; endproperty
	a_hi: assert property (p_hi) else $error("unmapped");
	cover property (w);
	cover property (irq_out);
	cover property (pslverr_out);
endmodule
bind peripheral_interrupt_enable periph_irq_checker periph_irq_checker_inst (.*);
`default_nettype wire

// ==== test/peripheral_interrupt_enable_tb_top.sv ====
// bench of the enable register block
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_enable_tb_top import periph_irq_pkg::*; ();
	logic        clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, pready_out, pslverr_out, irq_out, er;
	logic [11:0] paddr_in = 0;
	logic [31:0] pwdata_in = 0, prdata_out, rd;
	logic [7:0]  event_in = 0, enable_out;
	logic [3:0]  pstrb_in = 4'hf;
	int          errors = 0, checks = 0;
	peripheral_interrupt_enable peripheral_interrupt_enable_inst (.*);
	initial forever #10 clk_in = ~clk_in;
	task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
		checks++;
		errors += (s !== e);
		if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d = 0);
		@(posedge clk_in) {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
		@(posedge clk_in) penable_in <= 1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		{rd, er} = {prdata_out, pslverr_out};
		{psel_in, penable_in} <= 0;
	endtask
	task automatic report_and_stop;
		if (errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_regs;
		apb(0, ENABLE_ADDR);
		cmp("reset", ENABLE_RESET, rd);
		apb(1, ENABLE_ADDR, 32'hff);
		apb(0, ENABLE_ADDR);
		cmp("mask", LARGE_MASK, rd);
		pstrb_in <= 4'h0;
		apb(1, ENABLE_ADDR, 32'h0);
		pstrb_in <= 4'hf;
		apb(0, ENABLE_ADDR);
		cmp("strobe", LARGE_MASK, rd);
		apb(0, 12'hffc);
		cmp("unmapped", 1, er);
	endtask
	task automatic t_src(int b);
		apb(1, FLAG_ADDR, 32'hff);
		apb(1, CONTROL_ADDR);
		apb(1, ENABLE_ADDR, 1 << b);
		@(posedge clk_in) event_in <= 8'h1 << b;
		@(posedge clk_in) event_in <= 0;
		cmp("no master", 0, irq_out);
		apb(1, CONTROL_ADDR, 1);
		@(posedge clk_in);
		cmp("irq", 1, irq_out);
		apb(1, ENABLE_ADDR);
		@(posedge clk_in);
		cmp("masked", 0, irq_out);
		apb(0, FLAG_ADDR);
		cmp("flag", 1 << b, rd);
	endtask
	initial begin
		repeat (6) @(posedge clk_in);
		reset_in <= 0;
		t_regs;
		for (int b = 0; b < 8; b++) if (b != RESERVED_BIT) t_src(b);
		report_and_stop;
	end
	initial begin
		#100us;
		errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
